//--- core/can_tx_status_rx_fifo_flags.sv
// CAN transmit mailbox status and receive queue status registers
// Assumes engine event inputs are one-cycle pulses on aclk, except the
// levels mailbox_transmit_request and mbox_empty
//
// Summary of operation
// - Mailbox 0 done: set on finish, cleared
// - Mailbox 1 done: same set and clear
// - Mailbox 0 abort bit cleared once empty
// - Mailbox 0 fault flag set, cleared, restarted
// - Mailbox 0 arbitration-lost flag set and cleared
// - Mailbox 0 done-ok flag tracks error-free finish
// - Mailbox 1 done-ok reads zero after error
// - Queue 0 dequeue bit cleared when done
// - Queue 0 overfull flag sticky until written
// - Queue 0 full flag sticky until written
// - Queue 0 two-bit frame count readable
// - Queue 1 register and dequeue bit
// - Queue 1 overfull flag sticky until written
// - Queue 1 full flag sticky until written
// - Queue 1 two-bit frame count readable
// - Queue 0 full interrupt needs enable bit
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
module can_tx_status_rx_fifo_flags #(
  parameter int unsigned RXQ_DEPTH = can_status_pkg::RXQ_DEPTH
) (
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  // AXI4-Lite slave
  input  wire logic [can_status_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                              awvalid,
  output logic                                   awready,
  input  wire logic [31:0]                       wdata,
  input  wire logic [3:0]                        wstrb,
  input  wire logic                              wvalid,
  output logic                                   wready,
  output logic [1:0]                             bresp,
  output logic                                   bvalid,
  input  wire logic                              bready,
  input  wire logic [can_status_pkg::ADDR_W-1:0] araddr,
  input  wire logic                              arvalid,
  output logic                                   arready,
  output logic [31:0]                            rdata,
  output logic [1:0]                             rresp,
  output logic                                   rvalid,
  input  wire logic                              rready,
  // Transmit engine, per mailbox
  input  wire logic [1:0]                        tx_start,
  input  wire logic [1:0]                        tx_finish,
  input  wire logic [1:0]                        tx_finish_err,
  input  wire logic [1:0]                        tx_fault,
  input  wire logic [1:0]                        tx_arb_lost,
  input  wire logic [1:0]                        mbox_empty,
  input  wire logic [1:0]                        mailbox_transmit_request,
  output logic [1:0]                             mbox_abort_req,
  // Receive engine, per queue
  input  wire logic [1:0]                        rx_store,
  input  wire logic [1:0]                        rx_release_done,
  output logic [1:0]                             rx_release_req,
  // Interrupt
  output logic                                   irq
);

  localparam int unsigned AW = can_status_pkg::ADDR_W;
  localparam int unsigned IW = can_status_pkg::IRQ_W;
  localparam int unsigned CW = can_status_pkg::RXQ_CNT_W;

  // ------------------------------------------------------------
  // Register select
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    SEL_NONE = 6'b00_0001,
    SEL_TX   = 6'b00_0010,
    SEL_Q0   = 6'b00_0100,
    SEL_Q1   = 6'b00_1000,
    SEL_IEN  = 6'b01_0000,
    SEL_IST  = 6'b10_0000
  } sel_t;

  function automatic sel_t reg_sel(input logic [AW-1:0] a);
    sel_t s;
    case (a)
      can_status_pkg::TX_STATUS_OFF: s = SEL_TX;
      can_status_pkg::RXQ0_OFF:      s = SEL_Q0;
      can_status_pkg::RXQ1_OFF:      s = SEL_Q1;
      can_status_pkg::IRQ_EN_OFF:    s = SEL_IEN;
      can_status_pkg::IRQ_ST_OFF:    s = SEL_IST;
      default:                       s = SEL_NONE;
    endcase
    return s;
  endfunction : reg_sel

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic          aw_got;
    logic [AW-1:0] awaddr;
    logic          w_got;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic [1:0]    done;
    logic [1:0]    done_ok;
    logic [1:0]    arb_lost;
    logic [1:0]    tx_fault;
    logic [1:0]    abort_req;
    logic [IW-1:0] irq_st;
    logic [IW-1:0] irq_en;
  } state_t;

  state_t        s_q;
  state_t        s_d;
  logic          wr;
  logic          wr_ok;
  logic          word_wr;
  sel_t          wsel;
  sel_t          rsel;
  logic [31:0]   txw;
  logic [31:0]   qw0;
  logic [31:0]   qw1;
  logic [31:0]   rd;
  logic [IW-1:0] ev;
  logic [1:0]    q_store;
  logic [1:0]    q_rel_done;
  logic [1:0]    q_wr_rel;
  logic [1:0]    q_clr_full;
  logic [1:0]    q_clr_ovf;
  logic [1:0]    q_full_evt;
  logic [1:0]    q_ovf_evt;
  logic [1:0]    q_full;
  logic [1:0]    q_ovf;
  logic [1:0]    q_rel;
  logic [CW-1:0] q_cnt [2];

  rxq_if #(.CW(CW)) rxq [2] ();

  // ------------------------------------------------------------
  // Receive queue trackers
  // ------------------------------------------------------------
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_rxq
      assign rxq[g].store        = q_store[g];
      assign rxq[g].release_done = q_rel_done[g];
      assign rxq[g].wr_release   = q_wr_rel[g];
      assign rxq[g].clr_full     = q_clr_full[g];
      assign rxq[g].clr_ovf      = q_clr_ovf[g];
      assign q_full_evt[g]       = rxq[g].full_evt;
      assign q_ovf_evt[g]        = rxq[g].ovf_evt;
      assign q_full[g]           = rxq[g].full;
      assign q_ovf[g]            = rxq[g].ovf;
      assign q_rel[g]            = rxq[g].release_bit;
      assign q_cnt[g]            = rxq[g].count;

      rx_queue_track #(
        .DEPTH (RXQ_DEPTH),
        .CW    (CW)
      ) u_track (
        .aclk    (aclk),
        .aresetn (aresetn),
        .q       (rxq[g].queue)
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Field positions as plain ints for indexing
  // ------------------------------------------------------------
  localparam int MB_STRIDE_I   = can_status_pkg::MB_STRIDE;
  localparam int DONE_I        = can_status_pkg::MB_DONE;
  localparam int OK_I          = can_status_pkg::MB_OK;
  localparam int ARB_I         = can_status_pkg::MB_ARB;
  localparam int FAULT_I       = can_status_pkg::MB_FAULT;
  localparam int ABORT_I       = can_status_pkg::MB_ABORT;
  localparam int RXQ_RELEASE_I = can_status_pkg::RXQ_RELEASE;
  localparam int RXQ_OVF_I     = can_status_pkg::RXQ_OVF;
  localparam int RXQ_FULL_I    = can_status_pkg::RXQ_FULL;
  localparam int RXQ_CNT_I     = can_status_pkg::RXQ_CNT_LSB;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // Write channel capture, either order
    wr      = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
    wsel    = reg_sel(s_q.awaddr);
    // Partial-lane writes are refused so no flag is half-cleared
    word_wr = (s_q.wstrb == 4'hF);
    wr_ok   = wr & word_wr & (wsel != SEL_NONE);
    if (awvalid && awready)
    begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (wvalid && wready)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    if (wr)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = wr_ok ? can_status_pkg::RESP_OKAY
                         : can_status_pkg::RESP_SLVERR;
    end
    if (s_q.bvalid && bready)
      s_d.bvalid = 1'b0;

    txw = (wr_ok && wsel == SEL_TX) ? s_q.wdata : 32'h0000_0000;
    qw0 = (wr_ok && wsel == SEL_Q0) ? s_q.wdata : 32'h0000_0000;
    qw1 = (wr_ok && wsel == SEL_Q1) ? s_q.wdata : 32'h0000_0000;

    // Transmit mailboxes
    for (int i = 0; i < 2; i++)
    begin
      // Finish bit write-one also clears the dependent flags
      if (txw[i*MB_STRIDE_I + DONE_I] || mailbox_transmit_request[i])
        s_d.done[i] = 1'b0;
      if (tx_finish[i])
        s_d.done[i] = 1'b1;
      if (txw[i*MB_STRIDE_I + OK_I] || txw[i*MB_STRIDE_I + DONE_I]
          || (tx_finish[i] && tx_finish_err[i]))
        s_d.done_ok[i] = 1'b0;
      if (tx_finish[i] && !tx_finish_err[i])
        s_d.done_ok[i] = 1'b1;
      if (txw[i*MB_STRIDE_I + FAULT_I] || txw[i*MB_STRIDE_I + DONE_I]
          || tx_start[i])
        s_d.tx_fault[i] = 1'b0;
      if (tx_fault[i])
        s_d.tx_fault[i] = 1'b1;
      if (txw[i*MB_STRIDE_I + ARB_I] || txw[i*MB_STRIDE_I + DONE_I]
          || tx_start[i])
        s_d.arb_lost[i] = 1'b0;
      if (tx_arb_lost[i])
        s_d.arb_lost[i] = 1'b1;
      if (txw[i*MB_STRIDE_I + ABORT_I])
        s_d.abort_req[i] = 1'b1;
      // Empty mailbox has nothing to stop, so hardware wins here
      if (mbox_empty[i])
        s_d.abort_req[i] = 1'b0;
    end

    // Receive queue strobes
    q_store    = rx_store;
    q_rel_done = rx_release_done;
    q_wr_rel   = {qw1[RXQ_RELEASE_I], qw0[RXQ_RELEASE_I]};
    q_clr_full = {qw1[RXQ_FULL_I], qw0[RXQ_FULL_I]};
    q_clr_ovf  = {qw1[RXQ_OVF_I], qw0[RXQ_OVF_I]};

    // Interrupt status, set wins over write-one clear
    ev = '0;
    ev[can_status_pkg::IRQ_TXDONE] = |tx_finish;
    ev[can_status_pkg::IRQ_Q0FULL] = q_full_evt[0];
    ev[can_status_pkg::IRQ_Q0OVF]  = q_ovf_evt[0];
    ev[can_status_pkg::IRQ_Q1FULL] = q_full_evt[1];
    ev[can_status_pkg::IRQ_Q1OVF]  = q_ovf_evt[1];
    if (wr_ok && wsel == SEL_IST)
      s_d.irq_st = s_q.irq_st & ~s_q.wdata[IW-1:0];
    s_d.irq_st = s_d.irq_st | ev;
    if (wr_ok && wsel == SEL_IEN)
      s_d.irq_en = s_q.wdata[IW-1:0];

    // Read channel
    rsel = reg_sel(araddr);
    rd   = 32'h0000_0000;
    case (rsel)
      SEL_TX:
      begin
        for (int i = 0; i < 2; i++)
        begin
          rd[i*MB_STRIDE_I + DONE_I]  = s_q.done[i];
          rd[i*MB_STRIDE_I + OK_I]    = s_q.done_ok[i];
          rd[i*MB_STRIDE_I + ARB_I]   = s_q.arb_lost[i];
          rd[i*MB_STRIDE_I + FAULT_I] = s_q.tx_fault[i];
          rd[i*MB_STRIDE_I + ABORT_I] = s_q.abort_req[i];
        end
      end
      SEL_Q0:
      begin
        rd[RXQ_RELEASE_I] = q_rel[0];
        rd[RXQ_OVF_I]     = q_ovf[0];
        rd[RXQ_FULL_I]    = q_full[0];
        rd[RXQ_CNT_I +: CW] = q_cnt[0];
      end
      SEL_Q1:
      begin
        rd[RXQ_RELEASE_I] = q_rel[1];
        rd[RXQ_OVF_I]     = q_ovf[1];
        rd[RXQ_FULL_I]    = q_full[1];
        rd[RXQ_CNT_I +: CW] = q_cnt[1];
      end
      SEL_IEN:  rd[IW-1:0] = s_q.irq_en;
      SEL_IST:  rd[IW-1:0] = s_q.irq_st;
      default:  rd = 32'h0000_0000;
    endcase
    if (arvalid && arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd;
      s_d.rresp  = (rsel == SEL_NONE) ? can_status_pkg::RESP_SLVERR
                                      : can_status_pkg::RESP_OKAY;
    end
    else if (s_q.rvalid && rready)
      s_d.rvalid = 1'b0;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign awready        = ~s_q.aw_got & ~s_q.bvalid;
  assign wready         = ~s_q.w_got & ~s_q.bvalid;
  assign bvalid         = s_q.bvalid;
  assign bresp          = s_q.bresp;
  assign arready        = ~s_q.rvalid;
  assign rvalid         = s_q.rvalid;
  assign rdata          = s_q.rdata;
  assign rresp          = s_q.rresp;
  assign mbox_abort_req = s_q.abort_req;
  assign rx_release_req = q_rel;
  // Full of queue 0 reaches the line only through its enable bit
  assign irq            = |(s_q.irq_st & s_q.irq_en);

endmodule : can_tx_status_rx_fifo_flags

//--- core/rx_queue_track.sv
// Receive queue tracker: frame count, full, overfull and dequeue bit
// Assumes store and release_done are one-cycle pulses on aclk
`timescale 1ns/10ps
module rx_queue_track #(
  parameter int unsigned DEPTH = can_status_pkg::RXQ_DEPTH,
  parameter int unsigned CW    = can_status_pkg::RXQ_CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  rxq_if.queue     q
);

  generate
    if (DEPTH < 1 || DEPTH >= (1 << CW))
    begin : g_bad_depth
      $error("rx_queue_track: DEPTH does not fit the count field");
    end
  endgenerate

  typedef struct packed {
    logic [CW-1:0] count;
    logic          full;
    logic          ovf;
    logic          release_bit;
  } rxq_state_t;

  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  rxq_state_t s_q;
  rxq_state_t s_d;
  logic       done;
  logic       inc;
  logic       dec;

  always_comb
  begin
    s_d        = s_q;
    q.full_evt = 1'b0;
    q.ovf_evt  = 1'b0;
    done = s_q.release_bit & q.release_done;
    // A dequeue in the same cycle makes room for the new frame
    inc  = q.store && (s_q.count != DEPTH_C || done);
    dec  = done && (s_q.count != '0);
    if (done)
      s_d.release_bit = 1'b0;
    if (q.wr_release)
      s_d.release_bit = 1'b1;
    if (inc && !dec)
      s_d.count = s_q.count + 1'b1;
    else if (dec && !inc)
      s_d.count = s_q.count - 1'b1;
    if (q.store && s_q.count == DEPTH_C && !done)
      q.ovf_evt = 1'b1;
    if (inc && !dec && s_q.count == DEPTH_C - 1'b1)
      q.full_evt = 1'b1;
    // Clear first, then set: a new event is never lost
    if (q.clr_full)
      s_d.full = 1'b0;
    if (q.full_evt)
      s_d.full = 1'b1;
    if (q.clr_ovf)
      s_d.ovf = 1'b0;
    if (q.ovf_evt)
      s_d.ovf = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign q.count       = s_q.count;
  assign q.full        = s_q.full;
  assign q.ovf         = s_q.ovf;
  assign q.release_bit = s_q.release_bit;

endmodule : rx_queue_track

//--- pkg/can_status_pkg.sv
// Package: register map, field positions and reset values
// Assumes a 32-bit AXI4-Lite slave with byte addresses in an 8-bit window
package can_status_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] TX_STATUS_OFF = 8'h08;
  localparam logic [7:0] RXQ0_OFF      = 8'h0C;
  localparam logic [7:0] RXQ1_OFF      = 8'h10;
  localparam logic [7:0] IRQ_EN_OFF    = 8'h14;
  localparam logic [7:0] IRQ_ST_OFF    = 8'h24;

  // ------------------------------------------------------------
  // Transmit mailbox status fields, per mailbox at i*MB_STRIDE
  // ------------------------------------------------------------
  localparam int unsigned MB_STRIDE = 8;
  localparam int unsigned MB_DONE   = 0;
  localparam int unsigned MB_OK     = 1;
  localparam int unsigned MB_ARB    = 2;
  localparam int unsigned MB_FAULT  = 3;
  localparam int unsigned MB_ABORT  = 7;

  // ------------------------------------------------------------
  // Receive queue status fields
  // ------------------------------------------------------------
  localparam int unsigned RXQ_RELEASE = 5;
  localparam int unsigned RXQ_OVF     = 4;
  localparam int unsigned RXQ_FULL    = 3;
  localparam int unsigned RXQ_CNT_LSB = 0;
  localparam int unsigned RXQ_CNT_W   = 2;
  localparam int unsigned RXQ_DEPTH   = 3;

  // ------------------------------------------------------------
  // Interrupt status and enable layout
  // ------------------------------------------------------------
  localparam int unsigned IRQ_W      = 7;
  localparam int unsigned IRQ_TXDONE = 0;
  localparam int unsigned IRQ_Q0FULL = 2;
  localparam int unsigned IRQ_Q0OVF  = 3;
  localparam int unsigned IRQ_Q1FULL = 5;
  localparam int unsigned IRQ_Q1OVF  = 6;

  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : can_status_pkg

//--- pkg/rxq_if.sv
// Interface: register side to receive queue tracker
// Assumes both ends run on the same clock
`timescale 1ns/10ps
interface rxq_if #(parameter int unsigned CW = 2);
  logic          store;
  logic          release_done;
  logic          wr_release;
  logic          clr_full;
  logic          clr_ovf;
  logic [CW-1:0] count;
  logic          full;
  logic          ovf;
  logic          release_bit;
  logic          full_evt;
  logic          ovf_evt;

  modport ctrl  (output store, release_done, wr_release, clr_full, clr_ovf,
                 input  count, full, ovf, release_bit, full_evt, ovf_evt);
  modport queue (input  store, release_done, wr_release, clr_full, clr_ovf,
                 output count, full, ovf, release_bit, full_evt, ovf_evt);
endinterface : rxq_if

//--- tb/can_engine_model.sv
// Engine model: answers aborts and dequeues after DLY cycles
// Assumes load pulses from the bench mark a mailbox as filled
`timescale 1ns/10ps
module can_engine_model #(
  parameter int unsigned DLY = 4
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] load,
  input  wire logic [1:0] mbox_abort_req,
  input  wire logic [1:0] rx_release_req,
  output logic      [1:0] mbox_empty,
  output logic      [1:0] rx_release_done
);
  int unsigned ab_cnt_q [2];
  int unsigned rl_cnt_q [2];
  // ----------------------------------------------------------
  // One done pulse per request, never a late repeat
  // ----------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      rx_release_done[i] <= rl_cnt_q[i] == DLY;
      if (!aresetn || !rx_release_req[i])
        rl_cnt_q[i] <= 0;
      else if (rl_cnt_q[i] <= DLY)
        rl_cnt_q[i] <= rl_cnt_q[i] + 1;
      if (!aresetn)
        mbox_empty[i] <= 1'b1;
      else if (load[i])
        mbox_empty[i] <= 1'b0;
      else if (ab_cnt_q[i] == DLY)
        mbox_empty[i] <= 1'b1;
      ab_cnt_q[i] <= (aresetn && mbox_abort_req[i] && !mbox_empty[i]) ? ab_cnt_q[i] + 1 : 0;
    end
  end
endmodule : can_engine_model

//--- tb/can_status_monitor.sv
// Checker: bus timing, abort, dequeue and interrupt relations
// Assumes binding to the status block; sees only its ports
`timescale 1ns/10ps
module can_status_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [1:0]  tx_finish,
  input wire logic [1:0]  mbox_empty,
  input wire logic [1:0]  mbox_abort_req,
  input wire logic [1:0]  rx_store,
  input wire logic [1:0]  rx_release_done,
  input wire logic [1:0]  rx_release_req,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------
  // Sequences and assertions
  // ----------------------------------------------------------
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_take;
    arvalid && arready;
  endsequence
  chk_write_resp: assert property (wr_take |-> ##1 !bvalid ##1 bvalid)
    else $error("write response not on time");
  chk_read_resp: assert property (rd_take |=> rvalid)
    else $error("read data not on time");
  chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  chk_abort_clear: assert property (mbox_abort_req[0] && mbox_empty[0]
    |=> !mbox_abort_req[0])
    else $error("abort bit kept while empty");
  // Only a committed write may raise the abort bit
  chk_abort_set: assert property ($rose(mbox_abort_req[0]) |-> bvalid)
    else $error("abort bit rose without write");
  chk_deq0_clear: assert property (rx_release_req[0] && rx_release_done[0] && awready
    |=> !rx_release_req[0])
    else $error("queue 0 dequeue bit kept");
  chk_deq1_clear: assert property (rx_release_req[1] && rx_release_done[1] && awready
    |=> !rx_release_req[1])
    else $error("queue 1 dequeue bit kept");
  chk_irq_cause: assert property ($rose(irq) |-> $past(|rx_store) || $past(|tx_finish)
    || bvalid)
    else $error("interrupt without cause");
endmodule : can_status_monitor

bind can_tx_status_rx_fifo_flags can_status_monitor u_can_status_monitor (.*);

//--- tb/can_tx_status_rx_fifo_flags_test.sv
// Testbench: register tests of the CAN status block over AXI4-Lite
// Assumes the engine model answers aborts and dequeues in 8 cycles
`timescale 1ns/10ps
module can_tx_status_rx_fifo_flags_test;
  localparam logic [1:0] NIL = 2'h0;
  localparam logic [1:0] OK  = can_status_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = can_status_pkg::RESP_SLVERR;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, load, mailbox_transmit_request, mbox_abort_req;
  logic [1:0]  tx_start, tx_finish, tx_finish_err, tx_fault, tx_arb_lost;
  logic [1:0]  mbox_empty, rx_store, rx_release_done, rx_release_req;
  int          error_cnt, n_compared;

  can_tx_status_rx_fifo_flags u_can_tx_status_rx_fifo_flags (.*);
  can_engine_model #(.DLY(8)) u_can_engine_model (.*);

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // ----------------------------------------------------------
  // Bus and engine tasks
  // ----------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, s};
    {awvalid, wvalid} <= 2'h3;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    while (!bvalid) @(posedge aclk);
    // Late bready makes the slave hold its response a cycle
    bready <= 1'b1;
    @(posedge aclk);
    check(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b1;
    @(posedge aclk);
    check(32'(rresp), 32'(er));
    check(rdata, e);
    rready <= 1'b0;
  endtask : rd_chk

  task automatic eng(input logic [1:0] st, fin, err, flt, arb, sto);
    @(posedge aclk);
    {tx_start, tx_finish, tx_finish_err, tx_fault, tx_arb_lost, rx_store} <=
      {st, fin, err, flt, arb, sto};
    @(posedge aclk);
    {tx_start, tx_finish, tx_finish_err, tx_fault, tx_arb_lost, rx_store} <= '0;
  endtask : eng

  // Bounded wait for hardware to drop an abort or dequeue bit
  task automatic wait_clr(input logic [1:0] m);
    for (int i = 0; i < 40 && ((rx_release_req | mbox_abort_req) & m) !== 2'h0; i++)
      @(posedge aclk);
  endtask : wait_clr

  task automatic rxq(input logic [7:0] a, input logic [1:0] m);
    repeat (3) eng(NIL, NIL, NIL, NIL, NIL, m);
    rd_chk(a, 32'h0000_000B, OK);
    eng(NIL, NIL, NIL, NIL, NIL, m);
    rd_chk(a, 32'h0000_001B, OK);
    wr(a, 32'h0000_0018, 4'h3, ERR);
    wr(a, 32'h0000_0003, 4'hF, OK);
    rd_chk(a, 32'h0000_001B, OK);
    wr(a, 32'h0000_0018, 4'hF, OK);
    rd_chk(a, 32'h0000_0003, OK);
    wr(a, 32'h0000_0020, 4'hF, OK);
    wait_clr(m);
    check(32'(rx_release_req), 32'h0000_0000);
    rd_chk(a, 32'h0000_0002, OK);
  endtask : rxq

  task automatic stop_test();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------
  // Test sequence and watchdog
  // ----------------------------------------------------------
  initial
  begin
    #200000;
    error_cnt++;
    stop_test();
  end

  initial
  begin
    error_cnt = 0;
    n_compared = 0;
    aresetn <= 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} <= '0;
    {tx_start, tx_finish, tx_finish_err, tx_fault, tx_arb_lost, rx_store} <= '0;
    {mailbox_transmit_request, load} <= '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(8'h0C, can_status_pkg::REG_RESET, OK);
    rd_chk(8'h10, can_status_pkg::REG_RESET, OK);
    eng(NIL, 2'h1, NIL, NIL, NIL, NIL);
    rd_chk(8'h08, 32'h0000_0003, OK);
    eng(NIL, 2'h2, 2'h2, NIL, NIL, NIL);
    rd_chk(8'h08, 32'h0000_0103, OK);
    eng(NIL, NIL, NIL, 2'h1, 2'h1, NIL);
    wr(8'h08, 32'h0000_0000, 4'hF, OK);
    rd_chk(8'h08, 32'h0000_010F, OK);
    wr(8'h08, 32'h0000_0001, 4'hF, OK);
    rd_chk(8'h08, 32'h0000_0100, OK);
    eng(NIL, NIL, NIL, 2'h1, 2'h1, NIL);
    wr(8'h08, 32'h0000_0004, 4'hF, OK);
    rd_chk(8'h08, 32'h0000_0108, OK);
    eng(2'h1, NIL, NIL, NIL, NIL, NIL);
    rd_chk(8'h08, 32'h0000_0100, OK);
    eng(NIL, 2'h1, NIL, NIL, NIL, NIL);
    eng(NIL, 2'h3, 2'h1, NIL, NIL, NIL);
    rd_chk(8'h08, 32'h0000_0301, OK);
    @(posedge aclk);
    mailbox_transmit_request <= 2'h3;
    @(posedge aclk);
    mailbox_transmit_request <= 2'h0;
    rd_chk(8'h08, 32'h0000_0200, OK);
    wr(8'h40, 32'h0000_0001, 4'hF, ERR);
    @(posedge aclk);
    load <= 2'h1;
    @(posedge aclk);
    load <= 2'h0;
    wr(8'h08, 32'h0000_0080, 4'hF, OK);
    rd_chk(8'h08, 32'h0000_0280, OK);
    check(32'(mbox_abort_req), 32'h0000_0001);
    wait_clr(2'h1);
    check(32'(mbox_abort_req), 32'h0000_0000);
    rd_chk(8'h08, 32'h0000_0200, OK);
    wr(8'h24, 32'h0000_007F, 4'hF, OK);
    rxq(8'h0C, 2'h1);
    rd_chk(8'h24, 32'h0000_000C, OK);
    check(32'(irq), 32'h0000_0000);
    wr(8'h14, 32'h0000_0004, 4'hF, OK);
    check(32'(irq), 32'h0000_0001);
    wr(8'h24, 32'h0000_0004, 4'hF, OK);
    check(32'(irq), 32'h0000_0000);
    rxq(8'h10, 2'h2);
    rd_chk(8'h24, 32'h0000_0068, OK);
    stop_test();
  end
endmodule : can_tx_status_rx_fifo_flags_test
